// ===== sync_serial_pkg.sv
`default_nettype none
package sync_serial_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int          WORD_BITS   = 8;
  localparam logic [3:0]  BITS_RESET  = 4'h8;
  localparam logic [3:0]  BITS_ONE    = 4'h1;
  localparam logic [3:0]  BITS_ZERO   = 4'h0;

  // ----------------------------------------------------------------
  // phase check window around the latching edge, in clock cycles
  // ----------------------------------------------------------------
  localparam logic [1:0]  PH_POST_CYC = 2'h2;

  // ----------------------------------------------------------------
  // shift clock period measurement
  // ----------------------------------------------------------------
  localparam logic [16:0] PER_MAX     = 17'h1FFFF;
  localparam logic [16:0] PER_ZERO    = 17'h00000;

  // ----------------------------------------------------------------
  // error flag positions
  // ----------------------------------------------------------------
  localparam int          FLAG_RX     = 0;
  localparam int          FLAG_PH     = 1;
  localparam int          FLAG_RATE   = 2;
  localparam int          FLAG_TX     = 3;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_FRAME  = 2'b01,
    ST_EXPECT = 2'b10
  } frame_e;

endpackage
`default_nettype wire

// ===== sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff
#(
  parameter int WIDTH = 1
)
(
  // clock
  input  wire logic             i_clk,
  // async level in, synchronised level out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed
  {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // first stage is read by the second stage only
  always_comb
  begin
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_clk)
  begin
    st <= next_st;
  end

  assign o_sync = st.s2;

endmodule
`default_nettype wire

// ===== sync_serial_error_detection.sv
// Function
// - overrun/phase always; rate/underrun only as slave
// - unread word on frame end sets overrun
// - receive buffer overwritten by newest word
// - data change near latching edge: phase error
// - phase/rate flags always set; enables gate irq
// - slave clock beyond double/half rate: rate error
// - rate error with overrun enable self-resets
// - with rate enable, reloaded transmit buffer expects clock to continue
// - slave start without fresh write: underrun
// - stale shift register shifted out on underrun
// - flags persist; modify register sets/clears them
// - software flag set raises no interrupt
// - phase check stops when bit counter zero
`timescale 1ns/1ps
`default_nettype none
module sync_serial_error_detection
  import sync_serial_pkg::*;
(
  // system clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // serial link
  input  wire logic        i_sclk,
  input  wire logic        i_master_in_pin,
  input  wire logic        i_master_out_pin,
  input  wire logic        i_slave_select_n,
  output logic             o_slave_data_out,
  output logic             o_slave_data_oe,
  // configuration
  input  wire logic        i_slave_mode,
  input  wire logic        i_rx_overrun_enable,
  input  wire logic        i_phase_err_enable,
  input  wire logic        i_rate_err_enable,
  input  wire logic        i_tx_underrun_enable,
  input  wire logic [15:0] i_baud_cycles,
  // data buffers
  input  wire logic        i_tx_write,
  input  wire logic [7:0]  i_transmit_buffer,
  input  wire logic        i_rx_read,
  output logic      [7:0]  o_receive_buffer,
  output logic             o_rx_valid,
  // error flag modification
  input  wire logic        i_efm_write,
  input  wire logic [3:0]  i_efm_set,
  input  wire logic [3:0]  i_efm_clr,
  // status
  output logic             o_rx_overrun_flag,
  output logic             o_phase_err_flag,
  output logic             o_rate_err_flag,
  output logic             o_tx_underrun_flag,
  output logic             o_error_irq_line,
  output logic      [3:0]  o_transfer_bit_counter
);

  // ----------------------------------------------------------------
  // link domain (shift clock)
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] shreg;
    logic [3:0] bits;
    logic       tx_seen;
    logic       arst_seen;
    logic       done_tog;
    logic       under_tog;
    logic [7:0] rx_hold;
    logic       sdo;
  } link_s;

  typedef struct packed
  {
    logic       sclk_d;
    logic       din_d;
    logic       din_d2;
    logic       done_d;
    logic       under_d;
    logic [1:0] win;
    logic [3:0] bits;
    logic [16:0] per;
    frame_e     st;
    logic       tx_tog;
    logic [7:0] tx_word;
    logic       tx_pending;
    logic       arst_tog;
    logic [7:0] rbuf;
    logic       unread;
    logic [3:0] flags;
    logic       irq;
    logic       oe;
    logic       lrst;
  } core_s;

  link_s lk;
  link_s next_lk;
  core_s cr;
  core_s next_cr;

  logic [5:0] cr_sync;

  // the shift clock stops between frames, so a two-stage synchroniser
  // on it would lag by two edges; these registered controls settle
  // long before the edge that reads them and are read directly

  // pins and link events into the system clock domain
  sync_2ff #(.WIDTH(6)) u_sync_core
  (
    .i_clk   (i_clk),
    .i_async ({i_sclk, i_master_in_pin, i_master_out_pin, i_slave_select_n, lk.done_tog, lk.under_tog}),
    .o_sync  (cr_sync)
  );

  logic       lrst;
  logic       ltx_s;
  logic       larst_s;
  logic       lrestart;
  logic       lfresh;
  logic [7:0] lbase;
  logic [7:0] lnew;
  logic [3:0] lcnt;
  logic [3:0] lnbits;
  logic       ldin;

  assign lrst    = cr.lrst;
  assign ltx_s   = cr.tx_tog;
  assign larst_s = cr.arst_tog;
  assign ldin    = i_slave_mode ? i_master_out_pin : i_master_in_pin;

  // ----------------------------------------------------------------
  // link shift engine
  // ----------------------------------------------------------------
  // the shift clock may stop between frames, so the write and restart
  // crossings are toggles acted on at the next edge that does arrive
  always_comb
  begin
    next_lk  = lk;
    lrestart = (larst_s != lk.arst_seen);
    lcnt     = lrestart ? BITS_ZERO : lk.bits;
    lfresh   = (ltx_s != lk.tx_seen);
    lbase    = lk.shreg;
    if (lcnt == BITS_ZERO)
    begin
      lbase = lfresh ? cr.tx_word : lk.shreg;
      next_lk.tx_seen = ltx_s;
      if (!lfresh && i_slave_mode)
      begin
        next_lk.under_tog = ~lk.under_tog;
      end
    end
    lnew   = {lbase[6:0], ldin};
    lnbits = ((lcnt == BITS_ZERO) ? BITS_RESET : lcnt) - BITS_ONE;
    next_lk.arst_seen = larst_s;
    next_lk.shreg     = lnew;
    next_lk.bits      = lnbits;
    // msb leaves at the edge that loads the word
    next_lk.sdo       = lbase[7];
    if (lnbits == BITS_ZERO)
    begin
      next_lk.rx_hold  = lnew;
      next_lk.done_tog = ~lk.done_tog;
    end
    if (lrst)
    begin
      next_lk = '0;
      next_lk.tx_seen   = ltx_s;
      next_lk.arst_seen = larst_s;
    end
  end

  always_ff @(posedge i_sclk)
  begin
    lk <= next_lk;
  end

  // ----------------------------------------------------------------
  // error detection (system clock)
  // ----------------------------------------------------------------
  logic        sclk_s;
  logic        din_s;
  logic        sel_n_s;
  logic        done_s;
  logic        under_s;
  logic        sclk_rise;
  logic        chg;
  logic        chg_d1;
  logic        done_ev;
  logic        ov_ev;
  logic        ph_ev;
  logic        rate_ev;
  logic        tx_ev;
  logic [3:0]  hw_ev;
  logic [3:0]  en_vec;
  logic [16:0] per_hi;
  logic [16:0] per_lo;
  logic [3:0]  efm_set;
  logic [3:0]  efm_clr;

  function automatic logic [16:0] per_step(input logic [16:0] p);
    per_step = (p == PER_MAX) ? PER_MAX : p + 17'h00001;
  endfunction

  assign sclk_s  = cr_sync[5];
  assign din_s   = i_slave_mode ? cr_sync[3] : cr_sync[4];
  assign sel_n_s = cr_sync[2];
  assign done_s  = cr_sync[1];
  assign under_s = cr_sync[0];
  assign sclk_rise = sclk_s & ~cr.sclk_d;
  assign chg     = din_s ^ cr.din_d;
  assign chg_d1  = cr.din_d ^ cr.din_d2;
  assign done_ev = done_s ^ cr.done_d;
  assign per_hi  = {i_baud_cycles, 1'b0};
  assign per_lo  = {2'b00, i_baud_cycles[15:1]};
  assign en_vec  = {i_tx_underrun_enable, i_rate_err_enable, i_phase_err_enable, i_rx_overrun_enable};
  assign efm_set = i_efm_write ? i_efm_set : 4'h0;
  assign efm_clr = i_efm_write ? i_efm_clr : 4'h0;

  // one cycle before to two cycles after the latching edge
  assign ph_ev   = (sclk_rise & (chg | chg_d1)) | ((cr.win != 2'h0) & chg);

  // slave only; an edge too early or too late, or a missing edge
  assign rate_ev = i_slave_mode & (cr.st != ST_IDLE) &
                   ((sclk_rise & (cr.st == ST_FRAME) & (cr.per < per_lo)) |
                    (cr.per > per_hi));

  assign ov_ev   = done_ev & cr.unread & i_rx_overrun_enable;
  assign tx_ev   = (under_s ^ cr.under_d) & i_slave_mode & i_tx_underrun_enable;
  assign hw_ev   = {tx_ev, rate_ev, ph_ev, ov_ev};

  always_comb
  begin
    next_cr         = cr;
    next_cr.sclk_d  = sclk_s;
    next_cr.din_d   = din_s;
    next_cr.din_d2  = cr.din_d;
    next_cr.done_d  = done_s;
    next_cr.under_d = under_s;
    next_cr.oe      = i_slave_mode & ~sel_n_s;
    next_cr.lrst    = 1'b0;
    next_cr.per     = per_step(cr.per);
    next_cr.win     = (cr.win != 2'h0) ? cr.win - 2'h1 : 2'h0;
    if (i_tx_write)
    begin
      next_cr.tx_word = i_transmit_buffer;
      // one toggle per frame, so two writes never cancel out
      if (!cr.tx_pending)
      begin
        next_cr.tx_tog = ~cr.tx_tog;
      end
    end
    if (sclk_rise)
    begin
      next_cr.per  = PER_ZERO;
      next_cr.bits = ((cr.bits == BITS_ZERO) ? BITS_RESET : cr.bits) - BITS_ONE;
      next_cr.win  = PH_POST_CYC;
      next_cr.st   = ST_FRAME;
      if (cr.bits == BITS_ZERO)
      begin
        next_cr.tx_pending = 1'b0;
      end
      if (next_cr.bits == BITS_ZERO)
      begin
        next_cr.win = 2'h0;
        next_cr.st  = (cr.tx_pending && i_rate_err_enable) ? ST_EXPECT : ST_IDLE;
      end
    end
    if (i_tx_write)
    begin
      next_cr.tx_pending = 1'b1;
    end
    case (cr.st)
      ST_IDLE:   next_cr.per = sclk_rise ? PER_ZERO : cr.per;
      ST_FRAME:  ;
      ST_EXPECT: ;
      default:   next_cr.st = ST_IDLE;
    endcase
    if (rate_ev && !sclk_rise)
    begin
      next_cr.st = ST_IDLE;
    end
    if (rate_ev && i_rx_overrun_enable)
    begin
      next_cr.bits     = BITS_ZERO;
      next_cr.st       = ST_IDLE;
      next_cr.win      = 2'h0;
      next_cr.per      = PER_ZERO;
      next_cr.arst_tog = ~cr.arst_tog;
    end
    // unread is set by a new word even when read in the same cycle
    if (i_rx_read)
    begin
      next_cr.unread = 1'b0;
    end
    if (done_ev)
    begin
      next_cr.rbuf   = lk.rx_hold;
      next_cr.unread = 1'b1;
    end
    // set beats clear; software set does not reach the error line
    next_cr.flags = (cr.flags & ~efm_clr) | efm_set | hw_ev;
    next_cr.irq   = |(hw_ev & en_vec);
    if (i_rst)
    begin
      next_cr          = '0;
      next_cr.sclk_d   = sclk_s;
      next_cr.done_d   = done_s;
      next_cr.under_d  = under_s;
      next_cr.lrst     = 1'b1;
      next_cr.st       = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk)
  begin
    cr <= next_cr;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_slave_data_out       = lk.sdo;
  assign o_slave_data_oe        = cr.oe;
  assign o_receive_buffer       = cr.rbuf;
  assign o_rx_valid             = cr.unread;
  assign o_rx_overrun_flag      = cr.flags[FLAG_RX];
  assign o_phase_err_flag       = cr.flags[FLAG_PH];
  assign o_rate_err_flag        = cr.flags[FLAG_RATE];
  assign o_tx_underrun_flag     = cr.flags[FLAG_TX];
  assign o_error_irq_line       = cr.irq;
  assign o_transfer_bit_counter = cr.bits;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  flag_hold_a: assert property (o_rx_overrun_flag && !i_efm_write |=> o_rx_overrun_flag)
    else $error("overrun flag dropped without a clear");
  sw_set_quiet_a: assert property (i_efm_write && (i_efm_set != 4'h0) && (hw_ev == 4'h0)
    |=> !o_error_irq_line && ((cr.flags & $past(i_efm_set)) == $past(i_efm_set)))
    else $error("software flag set misbehaved");
  overrun_set_a: assert property (done_ev && o_rx_valid && i_rx_overrun_enable
    |=> o_rx_overrun_flag && o_error_irq_line)
    else $error("overrun not flagged");
  rbuf_overwrite_a: assert property (done_ev |=> o_receive_buffer == $past(lk.rx_hold) && o_rx_valid)
    else $error("receive buffer not overwritten");
  phase_window_a: assert property (sclk_rise && chg && !i_phase_err_enable
    |=> o_phase_err_flag && !o_error_irq_line || $past(hw_ev[3] || hw_ev[2] || hw_ev[0]))
    else $error("phase error near edge missed");
  phase_always_a: assert property (ph_ev |=> o_phase_err_flag ##1 o_phase_err_flag || $past(i_efm_write))
    else $error("phase flag not set");
  master_quiet_a: assert property (!i_slave_mode |-> !rate_ev && !tx_ev)
    else $error("slave only error raised in master mode");
  auto_reset_a: assert property (rate_ev && i_rx_overrun_enable |=> o_transfer_bit_counter == BITS_ZERO
    && cr.st == ST_IDLE)
    else $error("no self reset after rate error");
  phase_off_a: assert property (sclk_rise && cr.bits == BITS_ONE |=> cr.win == 2'h0)
    else $error("phase window open after last bit");
  underrun_set_a: assert property (tx_ev |=> o_tx_underrun_flag && o_error_irq_line)
    else $error("underrun not flagged");
  irq_enabled_a: assert property ((hw_ev & en_vec) == 4'h0 |=> !o_error_irq_line)
    else $error("error line without enabled event");

  overrun_c: cover property (ov_ev);
  phase_c:   cover property (ph_ev ##1 o_error_irq_line);
  rate_c:    cover property (rate_ev && cr.st == ST_EXPECT);
  under_c:   cover property (tx_ev);

endmodule
`default_nettype wire

// ===== far_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far side: serial master driving clock, data and select
// ----------------------------------------------------------------
module far_master
(
  // link outputs
  output var logic o_sclk,
  output var logic o_mosi,
  output var logic o_miso,
  output var logic o_ss_n,
  // slave data back
  input  wire logic i_sdo
);
  initial
  begin
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    o_miso = 1'b1;
    o_ss_n = 1'b1;
  end

  // a few edges while reset is held, so the link side resets too
  task automatic reset_pulses();
    #5;
    repeat (4)
    begin
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
  endtask

  // skew moves the data change onto the latching edge
  task automatic frame(input logic [7:0] d, input int half, input bit skew, output logic [7:0] got);
    int i;
    o_ss_n = 1'b0;
    #(half);
    for (i = 7; i >= 0; i--)
    begin
      if (!skew)
      begin
        o_mosi = d[i];
        o_miso = d[i];
      end
      #(half) o_sclk = 1'b1;
      if (skew)
      begin
        o_mosi = ~o_mosi;
        o_miso = ~o_miso;
      end
      #(half) o_sclk = 1'b0;
      got[i] = i_sdo;
    end
    #(half) o_ss_n = 1'b1;
    // released lines show the inverse, never the last bit
    o_mosi = ~o_mosi;
    o_miso = ~o_miso;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int HALF = 400;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_slave_mode = 1'b1;
  logic       i_rx_overrun_enable = 1'b1;
  logic       i_phase_err_enable = 1'b1;
  logic       i_rate_err_enable = 1'b1;
  logic       i_tx_underrun_enable = 1'b1;
  logic [15:0] i_baud_cycles = 16'h0010;
  logic       i_tx_write = 1'b0;
  logic [7:0] i_transmit_buffer = 8'h00;
  logic       i_rx_read = 1'b0;
  logic       i_efm_write = 1'b0;
  logic [3:0] i_efm_set = 4'h0;
  logic [3:0] i_efm_clr = 4'h0;
  wire logic  sclk, mosi, miso, ss_n;
  logic       o_slave_data_out, o_rx_valid, o_error_irq_line;
  logic       o_rx_overrun_flag, o_phase_err_flag, o_rate_err_flag, o_tx_underrun_flag;
  logic [7:0] o_receive_buffer;
  int         fails = 0;
  int         checks_done = 0;
  int         irq_cnt = 0;
  int         irq0;
  int         k;
  integer     seed = 26;
  logic [7:0] a;
  logic [7:0] g;
  // behavioural model state
  logic [7:0] tx_q[$];
  logic [7:0] shreg = 8'h00;
  logic [7:0] exp_flags = 8'h00;
  bit         valid = 0;

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_error_irq_line === 1'b1) irq_cnt <= irq_cnt + 1;

  sync_serial_error_detection u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_master_in_pin(miso), .i_master_out_pin(mosi),
    .i_slave_select_n(ss_n), .o_slave_data_out(o_slave_data_out), .o_slave_data_oe(),
    .i_slave_mode(i_slave_mode), .i_rx_overrun_enable(i_rx_overrun_enable),
    .i_phase_err_enable(i_phase_err_enable), .i_rate_err_enable(i_rate_err_enable),
    .i_tx_underrun_enable(i_tx_underrun_enable), .i_baud_cycles(i_baud_cycles), .i_tx_write(i_tx_write),
    .i_transmit_buffer(i_transmit_buffer), .i_rx_read(i_rx_read), .o_receive_buffer(o_receive_buffer),
    .o_rx_valid(o_rx_valid), .i_efm_write(i_efm_write), .i_efm_set(i_efm_set), .i_efm_clr(i_efm_clr),
    .o_rx_overrun_flag(o_rx_overrun_flag), .o_phase_err_flag(o_phase_err_flag),
    .o_rate_err_flag(o_rate_err_flag), .o_tx_underrun_flag(o_tx_underrun_flag),
    .o_error_irq_line(o_error_irq_line), .o_transfer_bit_counter());

  far_master u_far (.o_sclk(sclk), .o_mosi(mosi), .o_miso(miso), .o_ss_n(ss_n), .i_sdo(o_slave_data_out));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] flags();
    return {4'h0, o_tx_underrun_flag, o_rate_err_flag, o_phase_err_flag, o_rx_overrun_flag};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tx_wr(input logic [7:0] d);
    @(negedge i_clk);
    i_tx_write = 1'b1;
    i_transmit_buffer = d;
    tx_q.push_back(d);
    @(negedge i_clk);
    i_tx_write = 1'b0;
  endtask

  task automatic rx_rd();
    @(negedge i_clk);
    i_rx_read = 1'b1;
    valid = 0;
    @(negedge i_clk);
    i_rx_read = 1'b0;
  endtask

  task automatic error_flag_modify_reg(input logic [3:0] s, input logic [3:0] c);
    @(negedge i_clk);
    i_efm_write = 1'b1;
    i_efm_set = s;
    i_efm_clr = c;
    exp_flags = (exp_flags & ~{4'h0, c}) | {4'h0, s};
    @(negedge i_clk);
    i_efm_write = 1'b0;
    @(negedge i_clk);
  endtask

  // one frame; the model predicts word, flags and interrupt
  task automatic xfer(input logic [7:0] d, input int half, input bit skew);
    logic [7:0] got;
    logic [7:0] exp_out;
    int         i0;
    bit         ev;
    i0 = irq_cnt;
    ev = 0;
    exp_out = (tx_q.size() != 0) ? tx_q[0] : shreg;
    if (i_slave_mode && tx_q.size() == 0 && i_tx_underrun_enable)
    begin
      exp_flags[3] = 1'b1;
      ev = 1;
    end
    if (valid && i_rx_overrun_enable)
    begin
      exp_flags[0] = 1'b1;
      ev = 1;
    end
    tx_q.delete();
    shreg = d;
    valid = 1;
    u_far.frame(d, half, skew, got);
    // long gap: nothing was reloaded, so no clock is owed
    repeat (40) @(negedge i_clk);
    if (!skew && half == HALF)
    begin
      chk(o_receive_buffer, d);
      chk({7'h0, o_rx_valid}, 8'h01);
      chk(flags(), exp_flags);
      chk({7'h0, irq_cnt != i0}, {7'h0, ev});
      if (i_slave_mode) chk(got, exp_out);
    end
  endtask

  task automatic close_out();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    fork
      u_far.reset_pulses();
    join_none
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    tx_wr(8'($random(seed)));
    xfer(8'($random(seed)), HALF, 0);
    // no read, no reload: overrun and underrun together
    xfer(8'($random(seed)), HALF, 0);
    error_flag_modify_reg(4'h0, 4'hF);
    rx_rd();
    chk(flags(), 8'h00);
    irq0 = irq_cnt;
    error_flag_modify_reg(4'hF, 4'h0);
    chk(flags(), 8'h0F);
    chk({7'h0, irq_cnt != irq0}, 8'h00);
    error_flag_modify_reg(4'h0, 4'hF);
    for (k = 0; k < 2; k++)
    begin
      @(negedge i_clk);
      i_phase_err_enable = k[0];
      tx_wr(8'($random(seed)));
      irq0 = irq_cnt;
      xfer(8'($random(seed)), HALF, 1);
      chk(flags() & 8'h02, 8'h02);
      chk({7'h0, irq_cnt != irq0}, {7'h0, k[0]});
      rx_rd();
      error_flag_modify_reg(4'h0, 4'hF);
    end
    tx_wr(8'hFF);
    xfer(8'($random(seed)), HALF, 0);
    @(negedge i_clk);
    i_slave_mode = 1'b0;
    xfer(8'($random(seed)), HALF, 0);
    xfer(8'($random(seed)), HALF, 0);
    rx_rd();
    error_flag_modify_reg(4'h0, 4'hF);
    @(negedge i_clk);
    i_slave_mode = 1'b1;
    tx_wr(8'($random(seed)));
    fork
      u_far.frame(8'($random(seed)), HALF, 0, g);
      begin
        repeat (60) @(negedge i_clk);
        tx_wr(8'($random(seed)));
      end
    join
    repeat (60) @(negedge i_clk);
    chk(flags() & 8'h04, 8'h04);
    rx_rd();
    error_flag_modify_reg(4'h0, 4'hF);
    tx_wr(8'($random(seed)));
    xfer(8'($random(seed)), 16, 0);
    chk(flags() & 8'h04, 8'h04);
    error_flag_modify_reg(4'h0, 4'hF);
    @(negedge i_clk);
    i_slave_mode = 1'b0;
    xfer(8'($random(seed)), 16, 0);
    chk(flags() & 8'h0C, 8'h00);
    close_out();
  end

  initial
  begin
    #1000000;
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
